// [bench/nfc_guest_model.sv]
`timescale 1ns/10ps
`default_nettype none
module nfc_guest_model (
    // Bus clock and handshake
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Master request
    output logic             hsel,
    output logic      [7:0]  haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    // Wait overrun seen
    output logic             hang
);
    import nfc_pkg::*;

    // Idle bus from time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = SIZE_WORD;
        hwdata = 32'h00000000;
        hang   = 1'b0;
    end

    // Bounded wait; a stuck slave must not hang the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) hang = 1'b1;
    endtask : wait_rdy

    // One single-word transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= TRANS_NONSEQ;
        hwrite <= w;
        hsize  <= SIZE_WORD;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : xfer
endmodule : nfc_guest_model
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    import nfc_pkg::*;
    logic               hclk, hresetn, hsel, hwrite, hreadyout, hang, hresp;
    logic [31:0]        acc_feat;
    logic               link_up_in, announce_req_in, xfer_unit_load, cmd_queue_present;
    logic [7:0]         haddr;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    logic [31:0]        hwdata, hrdata, rd;
    logic [47:0]        station_addr_in;
    logic [15:0]        xfer_unit_in;
    nfc_pkt_t           pkt_in;
    nfc_verdict_t       verdict;
    int                 err_total = 0;
    int                 samples_checked = 0;

    nfc_config_space dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .station_addr_in(station_addr_in), .link_up_in(link_up_in),
        .announce_req_in(announce_req_in), .xfer_unit_in(xfer_unit_in), .xfer_unit_load(xfer_unit_load),
        .pkt_in(pkt_in), .verdict(verdict), .accepted_feat(acc_feat), .queue_pairs(),
        .cmd_queue_present(cmd_queue_present), .cmd_queue_index());

    nfc_guest_model drv (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang));

    // 100 MHz clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Compare and report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        drv.xfer(1'b1, a, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        drv.xfer(1'b0, a, 32'h00000000, rd);
        check(rd, exp);
    endtask : rd_chk

    // One packet query; verdict stands the cycle after valid
    task automatic pkt(input logic rx, input logic sg, input logic [15:0] len, input logic [1:0] exp);
        pkt_in <= '{valid: 1'b1, is_rx: rx, segmented: sg, length: len};
        @(posedge hclk);
        pkt_in <= '0;
        #1 check({30'h0, verdict}, {30'h0, exp});
        @(posedge hclk);
    endtask : pkt

    task automatic sc_reset();
        rd_chk(OFS_DRV_FEAT, DRV_FEAT_RST);
        rd_chk(8'h40, 32'h00000000);
    endtask : sc_reset

    // First load latches; the second value is held on load and ignored
    task automatic sc_unit();
        xfer_unit_in   <= 16'h05DC;
        xfer_unit_load <= 1'b1;
        @(posedge hclk);
        xfer_unit_in   <= 16'h2328;
        @(posedge hclk);
        xfer_unit_load <= 1'b0;
        rd_chk(OFS_XFER_LIMIT, 32'h000005DC);
        wr(OFS_XFER_LIMIT, 32'h0000FFFF);
        rd_chk(OFS_XFER_LIMIT, 32'h000005DC);
    endtask : sc_unit

    // Accepted word after dependency pruning
    task automatic sc_deps();
        logic [31:0] wv [10] = '{32'hFFFFFFFF, 32'h00007F80, 32'h00000202, 32'h00000282, 32'h00003001,
                                 32'h00002001, 32'h00000400, 32'h00EC0000, 32'h00EE0000, 32'h00100050};
        logic [31:0] ev [10] = '{32'h00EFFFAF, 32'h00000000, 32'h00000002, 32'h00000282, 32'h00003001,
                                 32'h00000001, 32'h00000000, 32'h00000000, 32'h00EE0000, 32'h00000000};
        foreach (wv[i]) begin
            wr(OFS_DRV_FEAT, wv[i]);
            rd_chk(OFS_DRV_FEAT, ev[i]);
            check(acc_feat, ev[i]);
            check({31'h0, hresp}, 32'h00000000);
        end
    endtask : sc_deps

    task automatic sc_queues();
        wr(OFS_DRV_FEAT, 32'h00420000);
        rd_chk(OFS_QUEUE_MAP, 32'h00080004);
        check({31'h0, cmd_queue_present}, 32'h00000001);
        rd_chk(OFS_PAIR_LIMIT, 32'h00000004);
        wr(OFS_QUEUE_QUERY, 32'h00000005);
        rd_chk(OFS_QUEUE_QUERY, 32'h80010003);
        wr(OFS_DRV_FEAT, 32'h00020000);
        rd_chk(OFS_QUEUE_MAP, 32'h00020001);
        wr(OFS_DRV_FEAT, 32'h00000000);
        rd_chk(OFS_DRV_FEAT, 32'h00000000);
        check({31'h0, cmd_queue_present}, 32'h00000000);
    endtask : sc_queues

    // Read-only fields, live flags, writes ignored
    task automatic sc_fields();
        wr(OFS_DRV_FEAT, 32'h00010020);
        rd_chk(OFS_ADDR_LO, 32'h2C3D4E5F);
        rd_chk(OFS_ADDR_HI, 32'h00000A1B);
        announce_req_in <= 1'b1;
        rd_chk(OFS_LINK_STATE, 32'h00000003);
        link_up_in <= 1'b0;
        rd_chk(OFS_LINK_STATE, 32'h00000002);
        wr(OFS_LINK_STATE, 32'h00000001);
        rd_chk(OFS_LINK_STATE, 32'h00000002);
        wr(OFS_DRV_FEAT, 32'h00000000);
        wr(OFS_ADDR_LO, 32'h00000000);
        rd_chk(OFS_ADDR_LO, 32'h2C3D4E5F);
    endtask : sc_fields

    // Limit 1500 plus 14 header bytes gives 1514 as the last length passed
    task automatic sc_packets();
        pkt(1'b1, 1'b0, 16'h05EB, 2'b10);
        wr(OFS_DRV_FEAT, 32'h00000008);
        rd_chk(OFS_PKT_CHECK, 32'h00000001);
        pkt(1'b1, 1'b0, 16'h05EA, 2'b10);
        pkt(1'b1, 1'b0, 16'h05EB, 2'b01);
        pkt(1'b1, 1'b1, 16'h2328, 2'b10);
        pkt(1'b0, 1'b0, 16'h05EA, 2'b10);
    endtask : sc_packets

    task automatic give_verdict();
        if (hang === 1'b1) err_total++;
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Main sequence
    initial begin
        hresetn         = 1'b0;
        link_up_in      = 1'b1;
        announce_req_in = 1'b0;
        station_addr_in = 48'h0A1B2C3D4E5F;
        xfer_unit_in    = 16'h0000;
        xfer_unit_load  = 1'b0;
        pkt_in          = '0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        sc_reset();
        sc_unit();
        sc_deps();
        sc_queues();
        sc_fields();
        sc_packets();
        give_verdict();
    end
endmodule : tb
`default_nettype wire

// [src/nfc_config_space.sv]
`timescale 1ns/10ps
`default_nettype none
module nfc_config_space #(
    parameter logic [31:0] OFFERED  = 32'h00EFFFEF,
    parameter logic        LEGACY   = 1'b0,
    parameter logic [15:0] PAIR_CNT = 16'h0004
) (
    // Bus clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [7:0]           haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic                 hready,
    input  wire logic [31:0]          hwdata,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // Device-side configuration sources
    input  wire logic [47:0]          station_addr_in,
    input  wire logic                 link_up_in,
    input  wire logic                 announce_req_in,
    input  wire logic [15:0]          xfer_unit_in,
    input  wire logic                 xfer_unit_load,
    // Packet length check
    input  wire nfc_pkg::nfc_pkt_t    pkt_in,
    output nfc_pkg::nfc_verdict_t     verdict,
    // Negotiation results
    output logic      [31:0]          accepted_feat,
    output logic      [15:0]          queue_pairs,
    output logic                      cmd_queue_present,
    output logic      [15:0]          cmd_queue_index
);
    import nfc_pkg::*;

    logic [31:0] drv_feat;
    logic [31:0] next_drv_feat;
    logic [15:0] transfer_unit_limit;
    logic        xfer_set;
    logic [15:0] queue_pair_limit;
    logic [15:0] query_index;
    logic [31:0] query_answer;
    logic [31:0] offered_eff;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        rd_pend;
    logic [7:0]  rd_addr;
    logic [31:0] rd_mux;
    logic        xfer_nego;
    logic [16:0] frame_limit;
    logic        req;

    // Bits offered, legacy any-segmentation bit only on legacy parts
    always_comb begin
        offered_eff             = OFFERED & FEAT_DEFINED;
        offered_eff[F_ANY_SEG]  = LEGACY & OFFERED[F_ANY_SEG];
        offered_eff[F_XFER_UNIT] = OFFERED[F_XFER_UNIT] & xfer_set;
    end

    // Pair limit clamped to the legal range
    always_comb begin
        if (PAIR_CNT == 16'h0000) begin
            queue_pair_limit = 16'h0001;
        end else if ({1'b0, PAIR_CNT} > PAIR_MAX) begin
            queue_pair_limit = PAIR_MAX[15:0];
        end else begin
            queue_pair_limit = PAIR_CNT;
        end
    end

    // Dependency filter on a feature write; unmet bits simply drop
    always_comb begin
        next_drv_feat = hwdata & offered_eff;
        if (!next_drv_feat[F_DRV_CSUM]) begin
            next_drv_feat[F_DRV_TCP4] = 1'b0;
            next_drv_feat[F_DRV_TCP6] = 1'b0;
            next_drv_feat[F_DRV_UDP]  = 1'b0;
        end
        if (!(next_drv_feat[F_DRV_TCP4] | next_drv_feat[F_DRV_TCP6])) begin
            next_drv_feat[F_DRV_CONG] = 1'b0;
        end
        if (!next_drv_feat[F_DEV_CSUM]) begin
            next_drv_feat[F_DEV_TCP4] = 1'b0;
            next_drv_feat[F_DEV_TCP6] = 1'b0;
            next_drv_feat[F_DEV_UDP]  = 1'b0;
        end
        if (!(next_drv_feat[F_DEV_TCP4] | next_drv_feat[F_DEV_TCP6])) begin
            next_drv_feat[F_DEV_CONG] = 1'b0;
        end
        if (!next_drv_feat[F_CMD_QUEUE]) begin
            next_drv_feat[F_CMD_RX_MODE] = 1'b0;
            next_drv_feat[F_VLAN_FILTER] = 1'b0;
            next_drv_feat[F_ANNOUNCE]    = 1'b0;
            next_drv_feat[F_MULTI_PAIR]  = 1'b0;
            next_drv_feat[F_CMD_ADDR]    = 1'b0;
        end
    end

    // Address phase capture; zero wait states
    assign req = hsel & hready & (htrans == TRANS_NONSEQ || htrans == TRANS_SEQ);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= req & hwrite;
            rd_pend <= req & ~hwrite;
            wr_addr <= haddr;
            rd_addr <= haddr;
        end
    end

    // Accepted feature word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drv_feat <= DRV_FEAT_RST;
        end else if (wr_pend && wr_addr == OFS_DRV_FEAT) begin
            drv_feat <= next_drv_feat;
        end
    end

    // Queue index query register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            query_index <= 16'h0000;
        end else if (wr_pend && wr_addr == OFS_QUEUE_QUERY) begin
            query_index <= hwdata[15:0];
        end
    end

    // Transfer unit latched once, clamped to 68 minimum, then frozen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transfer_unit_limit <= 16'h0000;
            xfer_set            <= 1'b0;
        end else if (xfer_unit_load && !xfer_set) begin
            transfer_unit_limit <= (xfer_unit_in < XFER_MIN) ? XFER_MIN : xfer_unit_in;
            xfer_set            <= 1'b1;
        end
    end

    // Negotiated queue layout
    assign accepted_feat     = drv_feat;
    assign queue_pairs       = drv_feat[F_MULTI_PAIR] ? queue_pair_limit : 16'h0001;
    assign cmd_queue_present = drv_feat[F_CMD_QUEUE];
    assign cmd_queue_index   = {queue_pairs[14:0], 1'b0};

    // Query answer: bit 31 valid, bit 16 transmit, bit 17 command, low pair
    always_comb begin
        query_answer = 32'h00000000;
        if (query_index[15:1] < queue_pairs[14:0] && queue_pairs[15] == 1'b0) begin
            query_answer[31]   = 1'b1;
            query_answer[16]   = query_index[0];
            query_answer[15:0] = {1'b0, query_index[15:1]} + 16'h0001;
        end else if (query_index == cmd_queue_index && cmd_queue_present) begin
            query_answer[31] = 1'b1;
            query_answer[17] = 1'b1;
        end
    end

    // Read data; absent fields read zero
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (rd_addr)
            OFS_DEV_FEAT:    rd_mux = offered_eff;
            OFS_DRV_FEAT:    rd_mux = drv_feat;
            OFS_ADDR_LO:     rd_mux = station_addr_in[31:0];
            OFS_ADDR_HI:     rd_mux = {16'h0000, station_addr_in[47:32]};
            OFS_LINK_STATE:  rd_mux = offered_eff[F_LINK_STATE] ?
                                      {16'h0000, (link_up_in ? LINK_UP_FLAG : 16'h0000) |
                                      (announce_req_in ? ANNOUNCE_REQ_FLAG : 16'h0000)} : 32'h00000000;
            OFS_PAIR_LIMIT:  rd_mux = offered_eff[F_MULTI_PAIR] ?
                                      {16'h0000, queue_pair_limit} : 32'h00000000;
            OFS_XFER_LIMIT:  rd_mux = offered_eff[F_XFER_UNIT] ?
                                      {16'h0000, transfer_unit_limit} : 32'h00000000;
            OFS_QUEUE_MAP:   rd_mux = {cmd_queue_index, queue_pairs};
            OFS_QUEUE_QUERY: rd_mux = query_answer;
            OFS_PKT_CHECK:   rd_mux = {31'h00000000, xfer_nego};
            default:         rd_mux = 32'h00000000;
        endcase
    end
    assign hrdata    = rd_pend ? rd_mux : 32'h00000000;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Packet length policy: only received unsegmented frames are judged
    assign xfer_nego   = drv_feat[F_XFER_UNIT];
    assign frame_limit = {1'b0, transfer_unit_limit} + {1'b0, LINK_HDR_LEN};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            verdict <= '0;
        end else begin
            verdict.deliver <= pkt_in.valid & ~(xfer_nego & ~pkt_in.segmented & pkt_in.is_rx
                               & ({1'b0, pkt_in.length} > frame_limit));
            verdict.drop    <= pkt_in.valid & xfer_nego & ~pkt_in.segmented & pkt_in.is_rx
                               & ({1'b0, pkt_in.length} > frame_limit);
        end
    end

    // Checks
    drv_dep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        drv_feat[F_DRV_TCP4] |-> drv_feat[F_DRV_CSUM]) else $error("driver offload without checksum");
    dev_dep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        drv_feat[F_DEV_CONG] |-> (drv_feat[F_DEV_TCP4] | drv_feat[F_DEV_TCP6])) else $error("device congestion dep");
    cmd_dep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        drv_feat[F_MULTI_PAIR] |-> drv_feat[F_CMD_QUEUE]) else $error("multi pair without command queue");
    gap_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (drv_feat[4] == 1'b0) && (drv_feat[20] == 1'b0)) else $error("unassigned bit accepted");
    pair_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        queue_pair_limit != 16'h0000 && {1'b0, queue_pair_limit} <= PAIR_MAX) else $error("pair limit range");
    unit_frozen_a: assert property (@(posedge hclk) disable iff (!hresetn)
        xfer_set |=> $stable(transfer_unit_limit)) else $error("unit limit changed");
    unit_min_a: assert property (@(posedge hclk) disable iff (!hresetn)
        xfer_set |-> transfer_unit_limit >= XFER_MIN) else $error("unit limit below minimum");
    rx_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pkt_in.valid && pkt_in.is_rx && !pkt_in.segmented && xfer_nego && {1'b0, pkt_in.length} > frame_limit)
        |=> verdict.drop && !verdict.deliver) else $error("oversize frame delivered");
    tx_fwd_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pkt_in.valid && !pkt_in.is_rx) |=> verdict.deliver) else $error("transmit frame not forwarded");
    cmd_idx_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !drv_feat[F_MULTI_PAIR] |-> cmd_queue_index == 16'h0002) else $error("command index wrong");
endmodule : nfc_config_space
`default_nettype wire

// [src/nfc_pkg.sv]
package nfc_pkg;
    // Feature bit positions
    localparam int F_DEV_CSUM         = 0;
    localparam int F_DRV_CSUM         = 1;
    localparam int F_CTRL_OFFLOADS    = 2;
    localparam int F_XFER_UNIT        = 3;
    localparam int F_STATION_ADDR     = 5;
    localparam int F_ANY_SEG          = 6;
    localparam int F_DRV_TCP4         = 7;
    localparam int F_DRV_TCP6         = 8;
    localparam int F_DRV_CONG         = 9;
    localparam int F_DRV_UDP          = 10;
    localparam int F_DEV_TCP4         = 11;
    localparam int F_DEV_TCP6         = 12;
    localparam int F_DEV_CONG         = 13;
    localparam int F_DEV_UDP          = 14;
    localparam int F_MERGED_RX        = 15;
    localparam int F_LINK_STATE       = 16;
    localparam int F_CMD_QUEUE        = 17;
    localparam int F_CMD_RX_MODE      = 18;
    localparam int F_VLAN_FILTER      = 19;
    localparam int F_ANNOUNCE         = 21;
    localparam int F_MULTI_PAIR       = 22;
    localparam int F_CMD_ADDR         = 23;
    localparam logic [31:0] FEAT_DEFINED = 32'h00EFFFEF;

    // Link state word flags
    localparam logic [15:0] LINK_UP_FLAG      = 16'h0001;
    localparam logic [15:0] ANNOUNCE_REQ_FLAG = 16'h0002;

    // Limits
    localparam logic [15:0] XFER_MIN       = 16'h0044;
    localparam logic [15:0] XFER_PREFERRED = 16'h0500;
    localparam logic [16:0] PAIR_MAX       = 17'h08000;
    localparam logic [15:0] LINK_HDR_LEN   = 16'h000E;

    // Register byte offsets
    localparam logic [7:0] OFS_DEV_FEAT    = 8'h00;
    localparam logic [7:0] OFS_DRV_FEAT    = 8'h04;
    localparam logic [7:0] OFS_ADDR_LO     = 8'h08;
    localparam logic [7:0] OFS_ADDR_HI     = 8'h0C;
    localparam logic [7:0] OFS_LINK_STATE  = 8'h10;
    localparam logic [7:0] OFS_PAIR_LIMIT  = 8'h14;
    localparam logic [7:0] OFS_XFER_LIMIT  = 8'h18;
    localparam logic [7:0] OFS_QUEUE_MAP   = 8'h1C;
    localparam logic [7:0] OFS_QUEUE_QUERY = 8'h20;
    localparam logic [7:0] OFS_PKT_CHECK   = 8'h24;

    // Reset values
    localparam logic [31:0] DRV_FEAT_RST = 32'h00000000;

    // AHB transfer and size codes
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TRANS_SEQ    = 2'h3;
    localparam logic [2:0] SIZE_WORD    = 3'h2;

    // Packet length check carrier
    typedef struct packed {
        logic        valid;
        logic        is_rx;
        logic        segmented;
        logic [15:0] length;
    } nfc_pkt_t;

    typedef struct packed {
        logic deliver;
        logic drop;
    } nfc_verdict_t;
endpackage : nfc_pkg
